/* rtl/asfp_defines.vh */
// Purpose: Shared constants for the asynchronous slave FIFO port
// Assumes: 25 MHz core clock
// Notes: Flag mode encodings and reset values
`ifndef ASFP_DEFINES_VH
`define ASFP_DEFINES_VH
`define ASFP_FLAG_EMPTY 2'h0
`define ASFP_FLAG_FULL 2'h1
`define ASFP_FLAG_PARTIAL 2'h2
`define ASFP_SYNC_RST 2'h3
`define ASFP_STROBE_IDLE 1'h1
`define ASFP_FLAG_RST 1'h1
`define ASFP_CTRL_PINS 5
`define ASFP_OFS_CS 1
`define ASFP_OFS_OE 2
`define ASFP_OFS_RD 3
`define ASFP_OFS_WR 4
`define ASFP_OFS_PE 5
`endif

/* rtl/asfp_fifo.v */
// Purpose: One FIFO of the slave port, flop storage with fill count
// Assumes: Writer and reader honour full and empty
// Notes: Commit records packet boundaries toward the USB side
module asfp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH_LOG2 = 3,
  parameter PARTIAL_LEVEL = 4
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Write side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire commit,
  // Read side
  input wire rd_en,
  output wire [WIDTH-1:0] rd_data,
  // Status
  output wire empty,
  output wire full,
  output wire partial,
  output reg commit_pulse,
  output reg commit_zero
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] wptr;
  reg [DEPTH_LOG2-1:0] rptr;
  reg [DEPTH_LOG2:0] count;
  reg [DEPTH_LOG2:0] pkt_count;
  wire do_wr = wr_en & ~full;
  wire do_rd = rd_en & ~empty;
  assign rd_data = mem[rptr];
  assign empty = (count == {(DEPTH_LOG2+1){1'b0}});
  assign full = (count == DEPTH[DEPTH_LOG2:0]);
  assign partial = (count >= PARTIAL_LEVEL[DEPTH_LOG2:0]);
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wptr] <= wr_data;
    end
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr <= {DEPTH_LOG2{1'b0}};
      rptr <= {DEPTH_LOG2{1'b0}};
      count <= {(DEPTH_LOG2+1){1'b0}};
      pkt_count <= {(DEPTH_LOG2+1){1'b0}};
      commit_pulse <= 1'b0;
      commit_zero <= 1'b0;
    end else begin
      if (do_wr) begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        rptr <= rptr + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
      // Commit covers the word written with it; zero-length when none pending
      commit_pulse <= commit;
      commit_zero <= commit & ~do_wr & (pkt_count == {(DEPTH_LOG2+1){1'b0}});
      if (commit) begin
        pkt_count <= {(DEPTH_LOG2+1){1'b0}};
      end else if (do_wr) begin
        pkt_count <= pkt_count + 1'b1;
      end
    end
  end
endmodule // asfp_fifo

/* rtl/asfp_port.v */
// Purpose: Asynchronous slave FIFO port, strobes sampled on the core clock
// Assumes: Master strobe widths exceed three core periods (sync plus edge)
// Notes: No interface clock; all master pins pass a two-flop synchroniser, flag setup inputs do not
`include "asfp_defines.vh"
// Functional notes
// R1: Master sets address and select before read
// R2: Drive bus only during output enable
// R3: Read strobe low presents current word
// R4: Read pointer advances on strobe release
// R5: Output enable and read may be tied
// R6: Burst read: present, then advance per pulse
// R7: Address and select no later than write
// R8: Write data valid around strobe release
// R9: Write strobe release stores word, advances
// R10: Flags update after write or commit release
// R11: Commit with last word ends short packet
// R12: Commit without write sends empty packet
// R13: Commit released at least 2ns after write
// R14: Flags selectable kind, fixed or current address
// R15: Master obeys flags for flow control
// R16: No select: ignore strobes, release bus
module asfp_port #(
  parameter WIDTH = 16,
  parameter ADDR_BITS = 2,
  parameter DEPTH_LOG2 = 3,
  parameter PARTIAL_LEVEL = 4
) (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // Master control pins
  input wire [ADDR_BITS-1:0] FIFO_SELECT_ADDR,
  input wire FIFO_CHIP_SELECT_N,
  input wire FIFO_OUTPUT_ENABLE_N,
  input wire FIFO_READ_STROBE_N,
  input wire FIFO_WRITE_STROBE_N,
  input wire PACKET_COMMIT_N,
  // Data bus
  input wire [WIDTH-1:0] DATA_IN,
  output reg [WIDTH-1:0] DATA_OUT,
  output wire DATA_OE,
  // Flag configuration
  input wire [1:0] FLAG_KIND,
  input wire FLAG_USE_FIXED,
  input wire [ADDR_BITS-1:0] FLAG_FIXED_ADDR,
  // Flag and USB side outputs
  output reg FLAG,
  output reg [(1<<ADDR_BITS)-1:0] PACKET_COMMITTED,
  output reg [(1<<ADDR_BITS)-1:0] PACKET_ZERO_LENGTH
);
  localparam NFIFO = 1 << ADDR_BITS;
  localparam NSYNC = `ASFP_CTRL_PINS + ADDR_BITS + WIDTH;

  // Synchroniser stages; the data bus is synchronised too, it is stable at release
  reg [NSYNC-1:0] sync1;
  reg [NSYNC-1:0] sync2;
  // Previous synchronised strobe levels
  reg rd_prev;
  reg wr_prev;
  reg pe_prev;
  // Last word seen while the write strobe was low
  reg [WIDTH-1:0] data_hold;
  // Next values
  reg [WIDTH-1:0] next_data_hold;
  reg [WIDTH-1:0] next_data_out;
  reg next_flag;
  reg [NFIFO-1:0] next_committed;
  reg [NFIFO-1:0] next_zero_length;

  // Raw pins as they enter the first flop
  wire [NSYNC-1:0] pins = {FIFO_CHIP_SELECT_N, FIFO_OUTPUT_ENABLE_N, FIFO_READ_STROBE_N,
    FIFO_WRITE_STROBE_N, PACKET_COMMIT_N, FIFO_SELECT_ADDR, DATA_IN};

  // Synchronised pin levels; nothing reads the raw pins or the first stage
  wire cs_n = sync2[NSYNC-`ASFP_OFS_CS];
  wire oe_n = sync2[NSYNC-`ASFP_OFS_OE];
  wire rd_n = sync2[NSYNC-`ASFP_OFS_RD];
  wire wr_n = sync2[NSYNC-`ASFP_OFS_WR];
  wire pe_n = sync2[NSYNC-`ASFP_OFS_PE];
  wire [ADDR_BITS-1:0] addr = sync2[WIDTH+ADDR_BITS-1:WIDTH];
  wire [WIDTH-1:0] din = sync2[WIDTH-1:0];

  // Strobes count only while selected; release is the active edge
  wire sel = ~cs_n; // R16
  wire rd_rise = sel & rd_n & ~rd_prev; // R4
  wire wr_rise = sel & wr_n & ~wr_prev; // R9
  wire pe_rise = sel & pe_n & ~pe_prev; // R11 R12
  // Read view: strobe or enable low, so a tied strobe and enable work alike
  wire rd_view = sel & (~rd_n | ~oe_n); // R3 R5

  // Per-FIFO status and data
  wire [NFIFO-1:0] f_empty;
  wire [NFIFO-1:0] f_full;
  wire [NFIFO-1:0] f_partial;
  wire [NFIFO-1:0] f_cpulse;
  wire [NFIFO-1:0] f_czero;
  wire [WIDTH*NFIFO-1:0] f_rdata;

  // Address decode, shared by the write, read and commit enables
  function addr_hit;
    input [ADDR_BITS-1:0] a;
    input integer idx;
    begin
      addr_hit = (a == idx[ADDR_BITS-1:0]);
    end
  endfunction

  // Bus enable from synchronised pins only; it trails the pins by two clocks
  assign DATA_OE = sel & ~oe_n; // R2 R16

  genvar g;
  generate
    for (g = 0; g < NFIFO; g = g + 1) begin : fifo_g
      asfp_fifo #(
        .WIDTH(WIDTH),
        .DEPTH_LOG2(DEPTH_LOG2),
        .PARTIAL_LEVEL(PARTIAL_LEVEL)
      ) u_fifo (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(wr_rise & addr_hit(addr, g)), // R9
        .wr_data(data_hold), // R8
        .commit(pe_rise & addr_hit(addr, g)), // R11 R12
        .rd_en(rd_rise & addr_hit(addr, g)), // R4 R6
        .rd_data(f_rdata[g*WIDTH +: WIDTH]),
        .empty(f_empty[g]),
        .full(f_full[g]),
        .partial(f_partial[g]),
        .commit_pulse(f_cpulse[g]),
        .commit_zero(f_czero[g])
      );
    end
  endgenerate

  // Flag kind select; the spare code reads as empty
  function flag_of;
    input [1:0] kind;
    input e, f, p;
    begin
      case (kind)
        `ASFP_FLAG_EMPTY: flag_of = e;
        `ASFP_FLAG_FULL: flag_of = f;
        `ASFP_FLAG_PARTIAL: flag_of = p;
        default: flag_of = e;
      endcase
    end
  endfunction

  wire [WIDTH-1:0] cur_rdata = f_rdata[addr*WIDTH +: WIDTH];
  wire [ADDR_BITS-1:0] flag_addr = FLAG_USE_FIXED ? FLAG_FIXED_ADDR : addr; // R14

  // Two-flop synchroniser, reset to all ones, the idle level of the active-low pins
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync1 <= {NSYNC{1'b1}};
      sync2 <= {NSYNC{1'b1}};
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // Strobe history reset high, so reset itself never looks like a release
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_prev <= `ASFP_STROBE_IDLE;
      wr_prev <= `ASFP_STROBE_IDLE;
      pe_prev <= `ASFP_STROBE_IDLE;
    end else begin
      rd_prev <= rd_n;
      wr_prev <= wr_n;
      pe_prev <= pe_n;
    end
  end

  // Write word taken while the strobe is low; the release sample may be stale
  always @* begin
    next_data_hold = data_hold;
    if (sel && !wr_n) begin
      next_data_hold = din; // R8
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      data_hold <= {WIDTH{1'b0}};
    end else begin
      data_hold <= next_data_hold;
    end
  end

  // Bus shows current word of the addressed FIFO; pointer moves only on release
  always @* begin
    next_data_out = DATA_OUT;
    if (rd_view) begin
      next_data_out = cur_rdata; // R3 R6
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DATA_OUT <= {WIDTH{1'b0}};
    end else begin
      DATA_OUT <= next_data_out;
    end
  end

  // Flag follows the fill state one clock after the store or read; a commit leaves the fill state unchanged
  always @* begin
    next_flag = flag_of(FLAG_KIND, f_empty[flag_addr], f_full[flag_addr],
      f_partial[flag_addr]); // R10 R14
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      FLAG <= `ASFP_FLAG_RST;
    end else begin
      FLAG <= next_flag;
    end
  end

  // Commit pulses toward the USB side, one clock each
  always @* begin
    next_committed = f_cpulse; // R11
    next_zero_length = f_czero; // R12
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PACKET_COMMITTED <= {NFIFO{1'b0}};
      PACKET_ZERO_LENGTH <= {NFIFO{1'b0}};
    end else begin
      PACKET_COMMITTED <= next_committed;
      PACKET_ZERO_LENGTH <= next_zero_length;
    end
  end
endmodule // asfp_port

/* tb/asfp_port_checker.sv */
// Purpose: Port assertions for the slave FIFO port
// Assumes: Flag setup static during traffic
// Notes: Delays are two sync flops plus edge detect
`include "asfp_defines.vh"
module asfp_port_checker #(
  parameter WIDTH = 16,
  parameter ADDR_BITS = 2
) (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // Pins
  input wire FIFO_CHIP_SELECT_N,
  input wire FIFO_OUTPUT_ENABLE_N,
  input wire FIFO_READ_STROBE_N,
  input wire FIFO_WRITE_STROBE_N,
  input wire PACKET_COMMIT_N,
  input wire [WIDTH-1:0] DATA_OUT,
  input wire DATA_OE,
  // Flags and pulses
  input wire [1:0] FLAG_KIND,
  input wire FLAG_USE_FIXED,
  input wire FLAG,
  input wire [(1<<ADDR_BITS)-1:0] PACKET_COMMITTED,
  input wire [(1<<ADDR_BITS)-1:0] PACKET_ZERO_LENGTH
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_oe_gate: assert property (DATA_OE |->
    $past(!FIFO_CHIP_SELECT_N && !FIFO_OUTPUT_ENABLE_N, 2)) else $error("bus driven unselected");
  a_oe_on: assert property ((!FIFO_CHIP_SELECT_N && !FIFO_OUTPUT_ENABLE_N)[*3] |-> DATA_OE)
    else $error("bus not driven");
  a_out_hold: assert property ((FIFO_OUTPUT_ENABLE_N && FIFO_READ_STROBE_N)[*3] |=>
    $stable(DATA_OUT)) else $error("read data moved");
  a_commit_lat: assert property ($rose(PACKET_COMMIT_N) && !FIFO_CHIP_SELECT_N |->
    ##4 PACKET_COMMITTED != 0) else $error("commit pulse late");
  a_zero_pair: assert property ((PACKET_ZERO_LENGTH & ~PACKET_COMMITTED) == 0)
    else $error("zero pulse alone");
  a_pulse_one: assert property (PACKET_COMMITTED != 0 |=> PACKET_COMMITTED == 0)
    else $error("commit pulse too long");
  a_quiet_unsel: assert property (FIFO_CHIP_SELECT_N[*5] |-> PACKET_COMMITTED == 0)
    else $error("commit unselected");
  a_flag_fill: assert property ($rose(FIFO_WRITE_STROBE_N) && !FIFO_CHIP_SELECT_N && FLAG
    && !FLAG_USE_FIXED && FLAG_KIND == `ASFP_FLAG_EMPTY |-> ##4 !FLAG)
    else $error("flag not updated");
endmodule // asfp_port_checker
bind asfp_port asfp_port_checker #(.WIDTH(WIDTH), .ADDR_BITS(ADDR_BITS)) i_asfp_port_checker (
  .CLK, .NRST, .FIFO_CHIP_SELECT_N, .FIFO_OUTPUT_ENABLE_N, .FIFO_READ_STROBE_N,
  .FIFO_WRITE_STROBE_N, .PACKET_COMMIT_N, .DATA_OUT, .DATA_OE, .FLAG_KIND,
  .FLAG_USE_FIXED, .FLAG, .PACKET_COMMITTED, .PACKET_ZERO_LENGTH);

/* tb/asfp_master.sv */
// Purpose: External master model on the slave FIFO pins
// Assumes: Four-cycle phases outlast the sync latency
// Notes: Released write data shows the inverted word
module asfp_master (
  // Clock
  input wire CLK,
  // Control and data
  output logic [1:0] FIFO_SELECT_ADDR,
  output logic FIFO_CHIP_SELECT_N,
  output logic FIFO_OUTPUT_ENABLE_N,
  output logic FIFO_READ_STROBE_N,
  output logic FIFO_WRITE_STROBE_N,
  output logic PACKET_COMMIT_N,
  output logic [15:0] DATA_IN,
  input wire [15:0] DATA_OUT,
  input wire DATA_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {FIFO_SELECT_ADDR, FIFO_CHIP_SELECT_N, FIFO_OUTPUT_ENABLE_N, FIFO_READ_STROBE_N,
    FIFO_WRITE_STROBE_N, PACKET_COMMIT_N, DATA_IN} = 23'h1f0000;
  task automatic put(input logic [1:0] ad, input logic [15:0] w, input logic we, pk);
    FIFO_SELECT_ADDR = ad;
    FIFO_CHIP_SELECT_N = 0;
    DATA_IN = w;
    FIFO_WRITE_STROBE_N = !we;
    PACKET_COMMIT_N = !pk;
    repeat (4) @(negedge CLK);
    FIFO_WRITE_STROBE_N = 1;
    @(negedge CLK);
    PACKET_COMMIT_N = 1;
    DATA_IN = ~w;
    repeat (4) @(negedge CLK);
  endtask
  task automatic get(input logic [1:0] ad, input logic hold, off, output logic [15:0] w);
    FIFO_SELECT_ADDR = ad;
    FIFO_CHIP_SELECT_N = off;
    FIFO_OUTPUT_ENABLE_N = 0;
    FIFO_READ_STROBE_N = 0;
    repeat (4) @(negedge CLK);
    w = DATA_OE ? DATA_OUT : 'x;
    FIFO_READ_STROBE_N = 1;
    FIFO_OUTPUT_ENABLE_N = !hold;
    repeat (4) @(negedge CLK);
  endtask
endmodule // asfp_master

/* tb/tb_asfp_port.sv */
// Purpose: Self-checking bench for the slave FIFO port
// Assumes: Master model paces every strobe
// Notes: Commit pulses are caught by a sticky monitor
module tb_asfp_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, NRST = 0, FLAG_USE_FIXED = 1, FIFO_CHIP_SELECT_N, FIFO_OUTPUT_ENABLE_N;
  logic FIFO_READ_STROBE_N, FIFO_WRITE_STROBE_N, PACKET_COMMIT_N, DATA_OE, FLAG;
  logic [1:0] FIFO_SELECT_ADDR, FLAG_KIND = 0, FLAG_FIXED_ADDR = 1;
  logic [15:0] DATA_IN, DATA_OUT, r;
  logic [3:0] PACKET_COMMITTED, PACKET_ZERO_LENGTH, sc, sz;
  logic mon_clr = 1;
  int errors = 0, n_tests = 0;
  asfp_port i_asfp_port (.CLK, .NRST, .FIFO_SELECT_ADDR, .FIFO_CHIP_SELECT_N,
    .FIFO_OUTPUT_ENABLE_N, .FIFO_READ_STROBE_N, .FIFO_WRITE_STROBE_N, .PACKET_COMMIT_N,
    .DATA_IN, .DATA_OUT, .DATA_OE, .FLAG_KIND, .FLAG_USE_FIXED, .FLAG_FIXED_ADDR, .FLAG,
    .PACKET_COMMITTED, .PACKET_ZERO_LENGTH);
  asfp_master i_asfp_master (.CLK, .FIFO_SELECT_ADDR, .FIFO_CHIP_SELECT_N, .FIFO_OUTPUT_ENABLE_N,
    .FIFO_READ_STROBE_N, .FIFO_WRITE_STROBE_N, .PACKET_COMMIT_N, .DATA_IN, .DATA_OUT, .DATA_OE);
  initial forever #20 CLK = ~CLK;
  always @(posedge CLK) begin
    if (mon_clr) begin
      sc <= 4'h0;
      sz <= 4'h0;
    end else begin
      sc <= sc | PACKET_COMMITTED;
      sz <= sz | PACKET_ZERO_LENGTH;
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_rw;
    chk(FLAG, 1);
    for (int i = 0; i < 3; i++) i_asfp_master.put(1, 16'ha5a0 + i, 1, 0);
    chk(FLAG, 0);
    for (int i = 0; i < 3; i++) begin
      i_asfp_master.get(1, i == 1, 0, r);
      chk(r, 16'ha5a0 + i);
    end
    chk(DATA_OE, 0);
    chk(FLAG, 1);
    $display("t_rw done");
  endtask
  task automatic t_kinds;
    FLAG_USE_FIXED = 0;
    FLAG_KIND = 1;
    for (int i = 0; i < 8; i++) begin
      i_asfp_master.put(2, 16'h0010 + i, 1, 0);
      chk(FLAG, i == 7);
    end
    for (int k = 0; k < 4; k++) begin
      FLAG_KIND = k;
      repeat (2) @(negedge CLK);
      chk(FLAG, k == 1 || k == 2);
    end
    FLAG_KIND = 1;
    i_asfp_master.get(2, 0, 1, r);
    chk(r, 'x);
    chk(FLAG, 1);
    $display("t_kinds done");
  endtask
  task automatic t_commit;
    FLAG_KIND = 0;
    mon_clr = 1;
    @(negedge CLK);
    mon_clr = 0;
    i_asfp_master.put(0, 16'h1234, 1, 1);
    i_asfp_master.put(3, 16'h0, 0, 1);
    repeat (4) @(negedge CLK);
    chk(sc, 4'h9);
    chk(sz, 4'h8);
    $display("t_commit done");
  endtask
  task automatic give_verdict;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    NRST = 1;
    @(negedge CLK);
    t_rw;
    t_kinds;
    t_commit;
    give_verdict;
  end
  initial begin
    #40us;
    errors++;
    give_verdict;
  end
endmodule // tb_asfp_port
